/* src/emad_pkg.sv */
// Package for the emulation memory area decoder.
// Assumes a single 20 MHz bus clock and switch inputs that are static in use.
package emad_pkg;

  localparam int ADDR_W          = 24;
  localparam int AREA_W          = 8;
  localparam int CODE_W          = 2;
  localparam int CODE_LSB        = 21;
  localparam int CODE_MSB        = 22;
  localparam int NUM_RAM         = 2;
  localparam int NUM_LOGIC       = 2;
  localparam int NUM_TARGETS     = 4;
  localparam int DATA_W          = 16;

  // Area switch positions, one-hot, position 7 unused
  localparam int AREA_EXT10      = 0;
  localparam int AREA_NINE_SEVENTEEN = 1;
  localparam int AREA_EIGHT_FOURTEEN = 2;
  localparam int AREA_SEVEN_THIRTEEN = 3;
  localparam int AREA_SIX_SEVEN_EIGHT = 4;
  localparam int AREA_FIVE_FIFTEEN = 5;
  localparam int AREA_FOUR_ELEVEN  = 6;
  localparam logic [AREA_W-1:0] AREA_USED_MASK = 8'h7F;

  // Defaults
  localparam logic [AREA_W-1:0] RAM_AREA_DEFAULT   = 8'h01;
  localparam logic [AREA_W-1:0] LOGIC_AREA_DEFAULT = 8'h02;
  localparam logic [1:0] BLOCK0_SW_DEFAULT = 2'h1;
  localparam logic [1:0] BLOCK1_SW_DEFAULT = 2'h0;

  // Target indices in priority order
  localparam int TGT_RAM0   = 0;
  localparam int TGT_RAM1   = 1;
  localparam int TGT_LOGIC0 = 2;
  localparam int TGT_LOGIC1 = 3;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [AREA_W-1:0] area_sel_n;
    logic              rd_n;
    logic              wrh_n;
    logic              wrl_n;
  } emad_bus_type;

  typedef struct packed {
    logic [NUM_TARGETS-1:0] select;
    logic                   ram_rd_n;
    logic                   ram_wrh_n;
    logic                   ram_wrl_n;
  } emad_route_type;

  typedef enum logic [1:0] {
    EMAD_SRC_NONE  = 2'h0,
    EMAD_SRC_RAM0  = 2'h1,
    EMAD_SRC_RAM1  = 2'h3,
    EMAD_SRC_LOGIC = 2'h2
  } emad_src_type;

endpackage

/* src/emad_decoder.sv */
// Area decoder of the emulation memory board: RAM block and user-logic selects,
// write-protect gate, reset and interrupt routing.
// Assumes bus inputs synchronous to sys_clk_in and switches held static.
`timescale 1ns/1ps

// Function
// [R01] With the reset link closed, the pushbutton or the target reset drives the interface reset.
// [R02] With the reset link open, no local source drives the interface reset, but an incoming one is still taken.
// [R03] Emulation RAM is two 2MB blocks, each with its own base setting.
// [R04] Each block matches address bits 22:21 against the inverted two-switch code.
// [R05] Bit 23 and above are ignored, so each block aliases at two windows.
// [R06] Default switches put block zero at code 10 and block one at code 11.
// [R07] A RAM block answers only when its chosen area select is low and the code matches.
// [R08] Configuration enables one area of seven per block; the eighth position is unused.
// [R09] A RAM block with no area enabled never answers.
// [R10] Both RAM blocks default to the external area 10 select only.
// [R11] Each user-logic block is enabled by one area select, area 9/17 by default, none meaning unused.
// [R12] With protection enabled, target-program writes to emulation RAM are blocked.
// [R13] Protection covers both RAM blocks together.
// [R14] Halted allows reads and writes; running with protection allows reads only.
// [R15] The debugger must drive the halted input whenever protection is enabled.
// [R16] With the interrupt link closed, user logic may drive the interface interrupt line.
// [R17] Overlapping matches go to RAM zero, then RAM one, then the logic blocks, one data source only.
module emad_decoder
  import emad_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  clk_en_in,
  // Processor bus
  input  wire emad_bus_type          bus_in,
  input  wire logic [DATA_W-1:0]     ram0_rdata_in,
  input  wire logic [DATA_W-1:0]     ram1_rdata_in,
  input  wire logic [DATA_W-1:0]     logic0_rdata_in,
  input  wire logic [DATA_W-1:0]     logic1_rdata_in,
  output logic [DATA_W-1:0]          bus_rdata_out,
  output logic                       bus_rdata_oe_out,
  // Switches
  input  wire logic [3:0]            ram_block_base_switches_in,
  input  wire logic [AREA_W-1:0]     ram_block0_area_select_in,
  input  wire logic [AREA_W-1:0]     ram_block1_area_select_in,
  input  wire logic [AREA_W-1:0]     logic_block0_area_select_in,
  input  wire logic [AREA_W-1:0]     logic_block1_area_select_in,
  input  wire logic                  write_protect_enable_in,
  input  wire logic                  debugger_halted_input_in,
  // Resource strobes
  output emad_route_type             route_out,
  output logic [1:0]                 ram_block_active_out,
  output logic [1:0]                 logic_block_active_out,
  // Reset routing
  input  wire logic                  reset_output_link_in,
  input  wire logic                  reset_button_n_in,
  input  wire logic                  user_target_reset_n_in,
  input  wire logic                  iface_reset_n_in,
  output logic                       iface_reset_n_out,
  output logic                       iface_reset_oe_out,
  output logic                       board_reset_n_out,
  // Interrupt routing
  input  wire logic                  interrupt_output_link_in,
  input  wire logic                  user_nmi_n_in,
  input  wire logic                  user_nmi_oe_in,
  output logic                       iface_nmi_n_out,
  output logic                       iface_nmi_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration capture

  logic [3:0]        base_sw_q;
  logic [AREA_W-1:0] area_cfg_q [NUM_TARGETS];
  logic              wp_en_q;
  logic              cfg_loaded_q;
  logic [AREA_W-1:0] area_cfg_d [NUM_TARGETS];

  assign area_cfg_d[TGT_RAM0]   = ram_block0_area_select_in & AREA_USED_MASK; // R08
  assign area_cfg_d[TGT_RAM1]   = ram_block1_area_select_in & AREA_USED_MASK;
  assign area_cfg_d[TGT_LOGIC0] = logic_block0_area_select_in & AREA_USED_MASK;
  assign area_cfg_d[TGT_LOGIC1] = logic_block1_area_select_in & AREA_USED_MASK;

  // Switches are sampled every enabled clock; reset holds the defaults
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      base_sw_q    <= {BLOCK1_SW_DEFAULT, BLOCK0_SW_DEFAULT}; // R06
      area_cfg_q   <= '{RAM_AREA_DEFAULT, RAM_AREA_DEFAULT,
                        LOGIC_AREA_DEFAULT, LOGIC_AREA_DEFAULT}; // R10 R11
      wp_en_q      <= 1'b0;
      cfg_loaded_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      base_sw_q    <= ram_block_base_switches_in;
      area_cfg_q   <= area_cfg_d;
      wp_en_q      <= write_protect_enable_in;
      cfg_loaded_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address and area decode

  logic [CODE_W-1:0]      addr_code;
  logic [NUM_TARGETS-1:0] area_hit;
  logic [NUM_TARGETS-1:0] target_used;
  logic [NUM_TARGETS-1:0] raw_match;
  logic [NUM_TARGETS-1:0] grant;
  logic [CODE_W-1:0]      ram_code [NUM_RAM];

  // Bit 23 and above never reach the compare
  assign addr_code = bus_in.addr[CODE_MSB:CODE_LSB]; // R05

  genvar g;
  generate
    for (g = 0; g < NUM_TARGETS; g++)
    begin : g_target
      // Area selects are active low; one-hot config picks the one that counts
      assign area_hit[g]    = |(area_cfg_q[g] & ~bus_in.area_sel_n); // R07 R11
      assign target_used[g] = |area_cfg_q[g]; // R09 R11
      if (g < NUM_RAM)
      begin : g_ram
        // Switch on means bit low: both off gives 11
        assign ram_code[g]  = ~base_sw_q[2*g +: 2]; // R03 R04
        assign raw_match[g] = target_used[g] & area_hit[g] & (addr_code == ram_code[g]); // R07
      end
      else
      begin : g_logic
        assign raw_match[g] = target_used[g] & area_hit[g];
      end
    end
  endgenerate

  // Fixed priority so a bad configuration never drives two sources
  assign grant[TGT_RAM0]   = raw_match[TGT_RAM0]; // R17
  assign grant[TGT_RAM1]   = raw_match[TGT_RAM1] & ~raw_match[TGT_RAM0];
  assign grant[TGT_LOGIC0] = raw_match[TGT_LOGIC0] & ~|raw_match[TGT_RAM1:TGT_RAM0];
  assign grant[TGT_LOGIC1] = raw_match[TGT_LOGIC1] & ~|raw_match[TGT_LOGIC0:TGT_RAM0];

  ////////////////////////////////////////////////////////////////////////////
  // Write protect and strobe gating

  logic write_block;
  logic ram_granted;

  // One enable for both blocks; halted debugger always allows writes
  assign write_block = wp_en_q & ~debugger_halted_input_in; // R12 R13 R14 R15
  assign ram_granted = |grant[TGT_RAM1:TGT_RAM0];

  assign route_out.select    = grant;
  assign route_out.ram_rd_n  = bus_in.rd_n | ~ram_granted; // R14
  assign route_out.ram_wrh_n = bus_in.wrh_n | ~ram_granted | write_block; // R12
  assign route_out.ram_wrl_n = bus_in.wrl_n | ~ram_granted | write_block; // R12

  assign ram_block_active_out   = target_used[TGT_RAM1:TGT_RAM0] & {2{cfg_loaded_q}};
  assign logic_block_active_out = target_used[TGT_LOGIC1:TGT_LOGIC0] & {2{cfg_loaded_q}};

  ////////////////////////////////////////////////////////////////////////////
  // Read data return

  emad_src_type      src_sel;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;
  logic              rdata_oe_q;

  assign src_sel = grant[TGT_RAM0] ? EMAD_SRC_RAM0 :
                   grant[TGT_RAM1] ? EMAD_SRC_RAM1 :
                   |grant[TGT_LOGIC1:TGT_LOGIC0] ? EMAD_SRC_LOGIC : EMAD_SRC_NONE;

  always_comb
  begin
    unique case (src_sel)
      EMAD_SRC_RAM0:  rdata_d = ram0_rdata_in; // R17
      EMAD_SRC_RAM1:  rdata_d = ram1_rdata_in;
      EMAD_SRC_LOGIC: rdata_d = grant[TGT_LOGIC0] ? logic0_rdata_in : logic1_rdata_in;
      EMAD_SRC_NONE:  rdata_d = '0;
    endcase
  end

  // Registered return: data stands one clock after the read cycle is seen
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rdata_q    <= 16'h0000;
      rdata_oe_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      rdata_q    <= rdata_d;
      rdata_oe_q <= ~bus_in.rd_n & (src_sel != EMAD_SRC_NONE);
    end
  end

  assign bus_rdata_out    = rdata_q;
  assign bus_rdata_oe_out = rdata_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Reset and interrupt routing

  logic local_reset_n;

  // Open-drain style: only pull low, never drive high
  assign local_reset_n      = reset_button_n_in & user_target_reset_n_in; // R01
  assign iface_reset_oe_out = reset_output_link_in & ~local_reset_n; // R01 R02
  assign iface_reset_n_out  = 1'b0;
  // Incoming reset is honoured whatever the link does
  assign board_reset_n_out  = iface_reset_n_in & (~reset_output_link_in | local_reset_n); // R02

  assign iface_nmi_oe_out = interrupt_output_link_in & user_nmi_oe_in; // R16
  assign iface_nmi_n_out  = user_nmi_n_in;

endmodule

/* verification/emad_checker_properties.sv */
// Port checker for the area decoder, bound into emad_decoder.
// Assumes clk_en_in high whenever switches change; decode checked once switches held two edges.
`timescale 1ns/1ps
module emad_checker
  import emad_pkg::*;
(
  // Clock, reset, bus
  input wire logic              sys_clk_in,
  input wire logic              rst_in,
  input wire emad_bus_type      bus_in,
  // Switches
  input wire logic [3:0]        ram_block_base_switches_in,
  input wire logic [AREA_W-1:0] ram_block0_area_select_in,
  input wire logic [AREA_W-1:0] ram_block1_area_select_in,
  input wire logic              write_protect_enable_in,
  input wire logic              debugger_halted_input_in,
  // Outputs and routing
  input wire emad_route_type    route_out,
  input wire logic [1:0]        ram_block_active_out,
  input wire logic              bus_rdata_oe_out,
  input wire logic              reset_output_link_in,
  input wire logic              reset_button_n_in,
  input wire logic              user_target_reset_n_in,
  input wire logic              iface_reset_n_in,
  input wire logic              iface_reset_oe_out,
  input wire logic              board_reset_n_out,
  input wire logic              interrupt_output_link_in,
  input wire logic              user_nmi_oe_in,
  input wire logic              iface_nmi_oe_out
);
  logic [21:0] cfg_q;
  logic        ok_q;
  wire  [21:0] cfg = {ram_block_base_switches_in, ram_block0_area_select_in, ram_block1_area_select_in,
                      write_protect_enable_in, debugger_halted_input_in};
  // Config registers lag the switches by one edge
  wire ok = ok_q && (cfg == cfg_q);
  wire hit0 = ok && bus_in.addr[22:21] == ~ram_block_base_switches_in[1:0]
              && |(ram_block0_area_select_in & ~bus_in.area_sel_n & AREA_USED_MASK);
  wire hit1 = ok && bus_in.addr[22:21] == ~ram_block_base_switches_in[3:2]
              && |(ram_block1_area_select_in & ~bus_in.area_sel_n & AREA_USED_MASK);
  wire lock = ok && write_protect_enable_in && !debugger_halted_input_in;
  always_ff @(posedge sys_clk_in or posedge rst_in)
    if (rst_in)
      ok_q <= 1'b0;
    else
      ok_q <= (cfg == cfg_q);
  always_ff @(posedge sys_clk_in)
    cfg_q <= cfg;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////
  property p_reset_drive;
    iface_reset_oe_out == (reset_output_link_in && !(reset_button_n_in && user_target_reset_n_in));
  endproperty
  a_reset_drive: assert property (p_reset_drive) else $error("reset line drive wrong");
  property p_reset_accept; !iface_reset_n_in |-> !board_reset_n_out; endproperty
  a_reset_accept: assert property (p_reset_accept) else $error("incoming reset ignored");
  property p_ram0_grant; hit0 |-> route_out.select == 4'h1; endproperty
  a_ram0_grant: assert property (p_ram0_grant) else $error("block zero not granted");
  property p_ram0_miss; ok && !hit0 |-> !route_out.select[0]; endproperty
  a_ram0_miss: assert property (p_ram0_miss) else $error("block zero granted on miss");
  property p_ram1_grant; hit1 && !hit0 |-> route_out.select == 4'h2; endproperty
  a_ram1_grant: assert property (p_ram1_grant) else $error("block one not granted");
  property p_unused; ok && !(|(ram_block0_area_select_in & AREA_USED_MASK)) |-> !ram_block_active_out[0]; endproperty
  a_unused: assert property (p_unused) else $error("unused block active");
  property p_protect; lock |-> route_out.ram_wrh_n && route_out.ram_wrl_n; endproperty
  a_protect: assert property (p_protect) else $error("write passed while protected");
  property p_write_pass; (hit0 || hit1) && ok && !lock |-> route_out.ram_wrl_n == bus_in.wrl_n; endproperty
  a_write_pass: assert property (p_write_pass) else $error("write strobe lost");
  property p_read_answer; hit0 && !bus_in.rd_n |=> bus_rdata_oe_out; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read data not driven");
  property p_nmi; iface_nmi_oe_out == (interrupt_output_link_in && user_nmi_oe_in); endproperty
  a_nmi: assert property (p_nmi) else $error("interrupt drive wrong");
endmodule
bind emad_decoder emad_checker chk_u (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus_in(bus_in),
  .ram_block_base_switches_in(ram_block_base_switches_in),
  .ram_block0_area_select_in(ram_block0_area_select_in),
  .ram_block1_area_select_in(ram_block1_area_select_in),
  .write_protect_enable_in(write_protect_enable_in),
  .debugger_halted_input_in(debugger_halted_input_in),
  .route_out(route_out), .ram_block_active_out(ram_block_active_out), .bus_rdata_oe_out(bus_rdata_oe_out),
  .reset_output_link_in(reset_output_link_in), .reset_button_n_in(reset_button_n_in),
  .user_target_reset_n_in(user_target_reset_n_in), .iface_reset_n_in(iface_reset_n_in),
  .iface_reset_oe_out(iface_reset_oe_out), .board_reset_n_out(board_reset_n_out),
  .interrupt_output_link_in(interrupt_output_link_in), .user_nmi_oe_in(user_nmi_oe_in),
  .iface_nmi_oe_out(iface_nmi_oe_out));

/* verification/emad_far_model.sv */
// Far-side resources: each answers with its index plus one and the low address bits.
// Assumes the address is held for the whole bus cycle.
`timescale 1ns/1ps
module emad_far_model
  import emad_pkg::*;
(
  // Bus address and read data per resource
  input  wire logic [ADDR_W-1:0]                  addr_in,
  output logic [NUM_TARGETS-1:0][DATA_W-1:0]      rdata_out
);
  // Address in the data, so stale words show up
  always_comb
    for (int i = 0; i < NUM_TARGETS; i++)
      rdata_out[i] = {4'(i + 1), addr_in[11:0]};
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the area decoder.
// Assumes the far model supplies read data; clk_en_in dropped once, with switches steady, to check the freeze.
`timescale 1ns/1ps
module tb_top;
  import emad_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  emad_bus_type bus = {24'h0, 8'hFF, 3'h7};
  logic [3:0] base = 4'h1;
  logic [7:0] a0 = 8'h01, a1 = 8'h01;
  logic [15:0] la = 16'h0202;
  logic wp = 1'b0, halted = 1'b1, ext_n = 1'b1;
  logic clk_en = 1'b1;
  logic [2:0] rs = 3'h3, ns = 3'h0;
  logic [NUM_TARGETS-1:0][DATA_W-1:0] rdata;
  logic [DATA_W-1:0] q;
  logic q_oe, r_oe, b_n, n_n, n_oe, r_n;
  emad_route_type route;
  logic [1:0] ram_act, log_act;
  int failures = 0, samples_checked = 0;
  // Open-drain reset line
  wire line_n = ext_n & (~r_oe | r_n);
  always #25 sys_clk_in = ~sys_clk_in;
  emad_far_model far_u (.addr_in(bus.addr), .rdata_out(rdata));
  emad_decoder dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en), .bus_in(bus),
    .ram0_rdata_in(rdata[0]), .ram1_rdata_in(rdata[1]), .logic0_rdata_in(rdata[2]), .logic1_rdata_in(rdata[3]),
    .bus_rdata_out(q), .bus_rdata_oe_out(q_oe), .ram_block_base_switches_in(base),
    .ram_block0_area_select_in(a0), .ram_block1_area_select_in(a1), .logic_block0_area_select_in(la[7:0]),
    .logic_block1_area_select_in(la[15:8]), .write_protect_enable_in(wp), .debugger_halted_input_in(halted),
    .route_out(route), .ram_block_active_out(ram_act), .logic_block_active_out(log_act),
    .reset_output_link_in(rs[2]), .reset_button_n_in(rs[1]), .user_target_reset_n_in(rs[0]),
    .iface_reset_n_in(line_n), .iface_reset_n_out(r_n), .iface_reset_oe_out(r_oe), .board_reset_n_out(b_n),
    .interrupt_output_link_in(ns[2]), .user_nmi_n_in(ns[1]), .user_nmi_oe_in(ns[0]),
    .iface_nmi_n_out(n_n), .iface_nmi_oe_out(n_oe));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (failures == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic setup(input logic [3:0] b, input logic [7:0] s0, s1, input logic [15:0] l, input logic w, h);
    @(negedge sys_clk_in);
    {base, a0, a1, la, wp, halted} = {b, s0, s1, l, w, h};
    repeat (3) @(negedge sys_clk_in);
  endtask
  // Strobes are rd_n, wrh_n, wrl_n
  task automatic cycle(input logic [23:0] a, input logic [7:0] sel_n, input logic [2:0] strb);
    @(negedge sys_clk_in);
    bus = {a, sel_n, strb};
    #1;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rst_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    cycle(24'hC00ABC, 8'hFE, 3'h3);
    check(route.select, 4'h1);
    @(posedge sys_clk_in);
    #1;
    check({q_oe, q}, {1'b1, 16'h1ABC});
    // Frozen clock enable must hold the last read word
    @(negedge sys_clk_in);
    clk_en = 1'b0;
    cycle(24'hE00000, 8'hFE, 3'h3);
    @(posedge sys_clk_in);
    #1;
    check({q_oe, q}, {1'b1, 16'h1ABC});
    @(negedge sys_clk_in);
    clk_en = 1'b1;
    cycle(24'h400123, 8'hFE, 3'h3);
    check(route.select, 4'h1);
    cycle(24'hE00000, 8'hFE, 3'h3);
    check(route.select, 4'h2);
    cycle(24'h200456, 8'hFE, 3'h3);
    check(route.select, 4'h0);
    cycle(24'h200456, 8'hFD, 3'h3);
    check(route.select, 4'h4);
    @(posedge sys_clk_in);
    #1;
    check(q, 16'h3456);
    for (int c = 0; c < 4; c++)
    begin
      setup({2'h0, ~c[1:0]}, 8'h01, 8'h00, 16'h0202, 1'b0, 1'b1);
      cycle({1'b1, c[1:0], 21'h0}, 8'hFE, 3'h3);
      check(route.select, 4'h1);
      cycle({1'b0, ~c[1:0], 21'h1FFFFF}, 8'hFE, 3'h3);
      check({ram_act, route.select}, 6'h10);
    end
    for (int a = 0; a < 7; a++)
    begin
      setup(4'h5, 8'h01 << a, 8'h01 << a, 16'h0, 1'b0, 1'b1);
      cycle(24'hC00000, ~(8'h01 << a), 3'h3);
      check(route.select, 4'h1);
      cycle(24'hC00000, 8'h7F, 3'h3);
      check(route.select, 4'h0);
    end
    setup(4'h1, 8'h00, 8'h80, 16'h0200, 1'b0, 1'b1);
    cycle(24'hC00000, 8'h00, 3'h3);
    check({ram_act, log_act, route.select}, 8'h28);
    for (int m = 0; m < 4; m++)
    begin
      setup(4'h4, 8'h01, 8'h01, 16'h0202, m[1], m[0]);
      cycle(24'hE00000, 8'hFE, 3'h4);
      check({route.ram_wrh_n, route.ram_wrl_n}, {2{m == 2}});
      cycle(24'hC00000, 8'hFE, 3'h5);
      check({route.select, route.ram_wrh_n, route.ram_wrl_n}, {4'h2, m == 2, 1'b1});
      cycle(24'hC00000, 8'hFE, 3'h3);
      check(route.ram_rd_n, 1'b0);
    end
    for (int k = 0; k < 16; k++)
    begin
      @(negedge sys_clk_in);
      {rs, ext_n} = k[3:0];
      ns = k[2:0];
      #1;
      check(r_oe, rs[2] & ~(rs[1] & rs[0]));
      check(line_n, ext_n & ~(rs[2] & ~(rs[1] & rs[0])));
      check(b_n, ext_n & (~rs[2] | (rs[1] & rs[0])));
      check({n_oe, n_n}, {ns[2] & ns[0], ns[1]});
    end
    complete_run();
  end
  // Run needs about 7 us
  initial
  begin
    #100us;
    failures++;
    complete_run();
  end
endmodule
